// *** rtl/rtcm_regs.vh ***
// Register offsets, field positions, reset values and timing figures of the clock block
`ifndef RTCM_REGS_VH
`define RTCM_REGS_VH

// Byte offsets
`define RTCM_OFS_CTRL 5'h00
`define RTCM_OFS_MATCH 5'h04
`define RTCM_OFS_IRQ_MASK 5'h10
`define RTCM_OFS_IRQ_STATUS 5'h14

// Control register fields
`define RTCM_CTRL_HOLD 0
`define RTCM_CTRL_MATCH_FLAG 2
`define RTCM_CTRL_WAKE_FLAG 3
`define RTCM_CTRL_ALARM_DPD 4
`define RTCM_CTRL_WAKE_DPD 5
`define RTCM_CTRL_FAST_EN 6
`define RTCM_CTRL_MAIN_EN 7
`define RTCM_CTRL_OSC_PD 8

// Interrupt status and mask fields
`define RTCM_IRQ_ALARM 0
`define RTCM_IRQ_WAKE 1

// Reset values
`define RTCM_MATCH_RESET 32'hffffffff
`define RTCM_MASK_RESET 2'h0

// Timing figures
`define RTCM_MCLK_HZ 20000000
`define RTCM_SEC_PERIOD_MS 1000
`define RTCM_FAST_PERIOD_US 1000

`endif

// *** rtl/rtcm_tick_gen.v ***
// Tick divider: one-cycle pulse every DIV clocks while run is high
`timescale 1ns/1ns
module rtcm_tick_gen #(
    parameter DIV = 20000,
    parameter CW = 25
) (
    input wire mclk,
    input wire reset_n,
    input wire run,
    output reg tick
);
    localparam integer LAST_FULL = DIV - 1;
    localparam [CW-1:0] LAST = LAST_FULL[CW-1:0];

    reg [CW-1:0] count;

    // Count restarts from zero whenever run drops, so the first tick is a full period late
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            count <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (count == LAST) begin
            count <= {CW{1'b0}};
            tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// *** rtl/rtcm_ctrl_match.v ***
// Clock control bits, seconds counter, alarm compare and Avalon-MM register slave
`timescale 1ns/1ns
`include "rtcm_regs.vh"

// Behaviour
// [R1] Wake timeout exits deep power-down only when enabled
// [R2] Fast enable starts and stops the 1 kHz tick
// [R3] Fast enable ignored while main enable is low
// [R4] Fast disabled: no wake, wake flag cleared
// [R5] Main enable low stops both ticks and counting
// [R6] Software sets main enable; seconds then run
// [R7] First seconds increment one second after enabling
// [R8] Software loads seconds only with main enable low; count_load loads at any time outside hold
// [R9] Oscillator power-down stops all clock ticks
// [R10] Seconds equal match sets alarm, and wake when enabled
// [R11] Software writes zero to upper control bits
// [R12] Alarm flag set on match, write one clears
// [R13] Wake flag set on timeout, write one clears
// [R14] Hold bit keeps all but oscillator bit reset
// [R15] Seconds count up once per second when running
// [R16] Alarm output follows alarm flag until cleared
module rtcm_ctrl_match #(
    parameter SEC_CYCLES = (`RTCM_MCLK_HZ / 1000) * `RTCM_SEC_PERIOD_MS,
    parameter FAST_CYCLES = (`RTCM_MCLK_HZ / 1000000) * `RTCM_FAST_PERIOD_US
) (
    input wire mclk,
    input wire reset_n,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire count_load,
    input wire [31:0] count_load_value,
    input wire wake_timer_expired,
    output reg [31:0] seconds_count,
    output reg sec_tick,
    output reg fast_tick,
    output reg alarm_irq,
    output reg wake_irq,
    output reg dpd_wake,
    output reg osc_powerdown_out,
    output reg irq
);
    // Control fields
    reg soft_reset_hold;
    reg seconds_match_flag;
    reg wake_timeout_flag;
    reg alarm_deep_pd_enable;
    reg wake_timer_deep_pd_enable;
    reg fast_clock_enable;
    reg main_clock_enable;
    reg osc_powerdown;

    // Other registers
    reg [31:0] alarm_compare_value;
    reg [1:0] irq_mask;

    // Bus state
    reg ack_phase;

    // Tick pulses from the dividers
    wire slow_pulse;
    wire fast_pulse;

    // Derived enables
    wire osc_running;
    wire slow_run;
    wire fast_run;

    // Bus decode
    wire [31:0] byte_mask;
    wire wr_commit;
    wire sel_ctrl;
    wire sel_match;
    wire sel_mask;
    wire sel_status;
    wire [31:0] wdata_m;
    wire ctrl_wr;

    // Event and clear terms
    wire match_hit;
    wire alarm_clr;
    wire wake_clr;
    wire wake_set;

    // Next values
    reg next_seconds_match_flag;
    reg next_wake_timeout_flag;
    reg [31:0] next_readdata;
    wire [1:0] status_bits;
    wire [1:0] next_status_bits;
    reg next_alarm_irq;
    reg next_wake_irq;
    reg next_dpd_wake;
    reg next_irq;

    // Handshake terms
    wire req_take;
    wire read_take;

    // Byte lanes expanded to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign byte_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
        end
    endgenerate

    // Write lands at the edge where waitrequest is seen low
    assign wr_commit = avs_write && !avs_waitrequest;
    assign sel_ctrl = (avs_address == `RTCM_OFS_CTRL);
    assign sel_match = (avs_address == `RTCM_OFS_MATCH);
    assign sel_mask = (avs_address == `RTCM_OFS_IRQ_MASK);
    assign sel_status = (avs_address == `RTCM_OFS_IRQ_STATUS);
    assign wdata_m = avs_writedata & byte_mask;
    assign ctrl_wr = wr_commit && sel_ctrl;
    assign req_take = (avs_read || avs_write) && !ack_phase;
    assign read_take = req_take && avs_read;

    // Oscillator gating and clock enables
    assign osc_running = !osc_powerdown; // [R9]
    assign slow_run = osc_running && main_clock_enable && !soft_reset_hold; // [R5] [R6]
    assign fast_run = slow_run && fast_clock_enable; // [R2] [R3]

    // One second divider; restarts on enable so first tick is one second later
    rtcm_tick_gen #(
        .DIV(SEC_CYCLES),
        .CW(25)
    ) u_slow (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(slow_run), // [R7]
        .tick(slow_pulse)
    );

    // Millisecond divider for the wake timer
    rtcm_tick_gen #(
        .DIV(FAST_CYCLES),
        .CW(25)
    ) u_fast (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(fast_run), // [R2]
        .tick(fast_pulse)
    );

    // Event and clear terms
    assign match_hit = (seconds_count == alarm_compare_value) && !soft_reset_hold; // [R10]
    assign alarm_clr = wr_commit && ((sel_ctrl && wdata_m[`RTCM_CTRL_MATCH_FLAG])
        || (sel_status && wdata_m[`RTCM_IRQ_ALARM])); // [R12]
    assign wake_clr = wr_commit && ((sel_ctrl && wdata_m[`RTCM_CTRL_WAKE_FLAG])
        || (sel_status && wdata_m[`RTCM_IRQ_WAKE])); // [R13]
    assign wake_set = wake_timer_expired && fast_run; // [R4]
    assign status_bits = {wake_timeout_flag, seconds_match_flag};

    // Flag next values; a set in the clearing cycle wins
    always @* begin
        next_seconds_match_flag = (seconds_match_flag && !alarm_clr) || match_hit; // [R12]
        next_wake_timeout_flag = (wake_timeout_flag && !wake_clr) || wake_set; // [R13]
        if (!fast_run) begin
            next_wake_timeout_flag = 1'b0; // [R4]
        end
        if (soft_reset_hold) begin
            next_seconds_match_flag = 1'b0; // [R14]
            next_wake_timeout_flag = 1'b0;
        end
    end

    // Hold bit; only a lane 0 write reaches it
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset_hold <= 1'b1;
        end else if (ctrl_wr && avs_byteenable[0]) begin
            soft_reset_hold <= avs_writedata[`RTCM_CTRL_HOLD]; // [R14]
        end
    end

    // Oscillator power-down, writable under hold like the hold bit itself
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            osc_powerdown <= 1'b0;
        end else if (ctrl_wr && avs_byteenable[1]) begin
            osc_powerdown <= avs_writedata[`RTCM_CTRL_OSC_PD]; // [R9] [R14]
        end
    end

    // Enable fields; writes ignored and forced to reset while held
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_deep_pd_enable <= 1'b0;
            wake_timer_deep_pd_enable <= 1'b0;
            fast_clock_enable <= 1'b0;
            main_clock_enable <= 1'b0;
        end else if (soft_reset_hold) begin
            alarm_deep_pd_enable <= 1'b0; // [R14]
            wake_timer_deep_pd_enable <= 1'b0;
            fast_clock_enable <= 1'b0;
            main_clock_enable <= 1'b0;
        end else if (wr_commit && sel_ctrl && avs_byteenable[0]) begin
            alarm_deep_pd_enable <= avs_writedata[`RTCM_CTRL_ALARM_DPD];
            wake_timer_deep_pd_enable <= avs_writedata[`RTCM_CTRL_WAKE_DPD];
            fast_clock_enable <= avs_writedata[`RTCM_CTRL_FAST_EN];
            main_clock_enable <= avs_writedata[`RTCM_CTRL_MAIN_EN]; // [R6]
        end
    end

    // Sticky flags
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seconds_match_flag <= 1'b0;
            wake_timeout_flag <= 1'b0;
        end else begin
            seconds_match_flag <= next_seconds_match_flag;
            wake_timeout_flag <= next_wake_timeout_flag;
        end
    end

    // Match value, written per byte lane
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_compare_value <= `RTCM_MATCH_RESET;
        end else if (soft_reset_hold) begin
            alarm_compare_value <= `RTCM_MATCH_RESET; // [R14]
        end else if (wr_commit && sel_match) begin
            alarm_compare_value <= (alarm_compare_value & ~byte_mask) | wdata_m;
        end
    end

    // Interrupt mask, lane 0 only
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= `RTCM_MASK_RESET;
        end else if (soft_reset_hold) begin
            irq_mask <= `RTCM_MASK_RESET; // [R14]
        end else if (wr_commit && sel_mask && avs_byteenable[0]) begin
            irq_mask <= avs_writedata[1:0];
        end
    end

    // Seconds counter: load from outside, else count on each second
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seconds_count <= 32'h00000000;
        end else if (soft_reset_hold) begin
            seconds_count <= 32'h00000000; // [R14]
        end else if (count_load) begin
            seconds_count <= count_load_value; // [R8]
        end else if (slow_pulse) begin
            seconds_count <= seconds_count + 32'h00000001; // [R15]
        end
    end

    // Tick outputs for the wake timer and the seconds domain
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sec_tick <= 1'b0;
            fast_tick <= 1'b0;
        end else begin
            sec_tick <= slow_pulse; // [R5]
            fast_tick <= fast_pulse; // [R2] [R3]
        end
    end

    // Pin next values; a flag shows at its pin in the cycle it is stored
    assign next_status_bits = {next_wake_timeout_flag, next_seconds_match_flag};

    // Interrupt and wake levels before registering
    always @* begin
        next_alarm_irq = next_seconds_match_flag; // [R16] [R10]
        next_wake_irq = next_wake_timeout_flag; // [R13]
        next_dpd_wake = 1'b0;
        if (next_seconds_match_flag && alarm_deep_pd_enable) begin
            next_dpd_wake = 1'b1; // [R10]
        end
        if (next_wake_timeout_flag && wake_timer_deep_pd_enable) begin
            next_dpd_wake = 1'b1; // [R1]
        end
        next_irq = |(next_status_bits & irq_mask);
    end

    // Interrupt, wake and oscillator outputs
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_irq <= 1'b0;
            wake_irq <= 1'b0;
            dpd_wake <= 1'b0;
            osc_powerdown_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            alarm_irq <= next_alarm_irq; // [R16] [R10]
            wake_irq <= next_wake_irq; // [R13]
            dpd_wake <= next_dpd_wake; // [R1] [R10]
            osc_powerdown_out <= osc_powerdown; // [R9]
            irq <= next_irq;
        end
    end

    // Read data mux; unmapped offsets read zero
    always @* begin
        next_readdata = 32'h00000000;
        if (sel_ctrl) begin
            next_readdata[`RTCM_CTRL_HOLD] = soft_reset_hold;
            next_readdata[`RTCM_CTRL_MATCH_FLAG] = seconds_match_flag;
            next_readdata[`RTCM_CTRL_WAKE_FLAG] = wake_timeout_flag;
            next_readdata[`RTCM_CTRL_ALARM_DPD] = alarm_deep_pd_enable;
            next_readdata[`RTCM_CTRL_WAKE_DPD] = wake_timer_deep_pd_enable;
            next_readdata[`RTCM_CTRL_FAST_EN] = fast_clock_enable;
            next_readdata[`RTCM_CTRL_MAIN_EN] = main_clock_enable;
            next_readdata[`RTCM_CTRL_OSC_PD] = osc_powerdown; // [R11]
        end else if (sel_match) begin
            next_readdata = alarm_compare_value;
        end else if (sel_mask) begin
            next_readdata[1:0] = irq_mask;
        end else if (sel_status) begin
            next_readdata[1:0] = status_bits;
        end
    end

    // Avalon handshake: one wait cycle, then waitrequest low for one cycle
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_phase <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else if (ack_phase) begin
            ack_phase <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else if (req_take) begin
            ack_phase <= 1'b1;
            avs_waitrequest <= 1'b0;
        end
    end

    // Read data taken in the request cycle; stands until the next read answer
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (read_take) begin
            avs_readdata <= next_readdata;
        end
    end
endmodule

// *** verification/rtcm_properties.sv ***
// Concurrent checks on the clock control and alarm block ports
`timescale 1ns/1ns
module rtcm_properties #(
    parameter SEC_CYCLES = 20,
    parameter FAST_CYCLES = 5
) (
    input wire mclk,
    input wire reset_n,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire count_load,
    input wire [31:0] count_load_value,
    input wire wake_timer_expired,
    input wire [31:0] seconds_count,
    input wire sec_tick,
    input wire fast_tick,
    input wire alarm_irq,
    input wire wake_irq,
    input wire dpd_wake,
    input wire osc_powerdown_out,
    input wire irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Quiet stretches after a tick
    sequence s_fast_quiet;
        !fast_tick [*4];
    endsequence
    sequence s_sec_quiet;
        !sec_tick [*8];
    endsequence
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_rdata_moves: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
        else $error("readdata changed outside an answer");
    a_alarm_clear: assert property ($fell(alarm_irq) |-> $past(avs_write && !avs_waitrequest))
        else $error("alarm dropped without a write");
    a_alarm_cause: assert property ($rose(alarm_irq) |->
        $past(seconds_count) != $past(seconds_count, 2) || $past(avs_write) || $past(avs_write, 2))
        else $error("alarm rose without a cause");
    a_wake_source: assert property ($rose(wake_irq) |-> $past(wake_timer_expired))
        else $error("wake rose without timeout");
    a_count_step: assert property ($changed(seconds_count) && !$past(count_load)
        && !$past(avs_write) && !$past(avs_write, 2)
        |-> seconds_count == $past(seconds_count) + 32'h1)
        else $error("seconds moved by other than one");
    a_tick_follow: assert property (seconds_count == $past(seconds_count) + 32'h1
        && !$past(count_load) && !$past(avs_write) && !$past(avs_write, 2) |-> sec_tick)
        else $error("no tick after increment");
    a_sec_space: assert property (sec_tick |=> s_sec_quiet)
        else $error("seconds ticks too close");
    a_fast_space: assert property (fast_tick |=> s_fast_quiet)
        else $error("fast ticks too close");
    a_osc_quiet: assert property (osc_powerdown_out && $past(osc_powerdown_out) |-> !fast_tick)
        else $error("fast tick while oscillator down");
endmodule

bind rtcm_ctrl_match rtcm_properties #(.SEC_CYCLES(SEC_CYCLES), .FAST_CYCLES(FAST_CYCLES)) i_props (
    .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .count_load(count_load),
    .count_load_value(count_load_value), .wake_timer_expired(wake_timer_expired),
    .seconds_count(seconds_count), .sec_tick(sec_tick), .fast_tick(fast_tick),
    .alarm_irq(alarm_irq), .wake_irq(wake_irq), .dpd_wake(dpd_wake),
    .osc_powerdown_out(osc_powerdown_out), .irq(irq));

// *** verification/testbench.sv ***
// Self-checking bench for the clock control and alarm block
`timescale 1ns/1ns
module testbench;
    localparam SEC = 20;
    reg mclk = 1'h0, reset_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    reg count_load = 1'h0, wake_timer_expired = 1'h0;
    reg [4:0] avs_address = 5'h00;
    reg [31:0] avs_writedata = 32'h0, count_load_value = 32'h0, v, c;
    reg [3:0] avs_byteenable = 4'hf;
    wire [31:0] avs_readdata, seconds_count;
    wire avs_waitrequest, sec_tick, fast_tick, alarm_irq, wake_irq, dpd_wake, osc_powerdown_out, irq;
    integer fails = 0, samples_checked = 0, cycles = 0, fast_n = 0, n, seed = 23438;
    logic [31:0] expq[$];

    rtcm_ctrl_match #(.SEC_CYCLES(SEC), .FAST_CYCLES(5)) i_dut (.mclk(mclk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .count_load(count_load),
        .count_load_value(count_load_value), .wake_timer_expired(wake_timer_expired),
        .seconds_count(seconds_count), .sec_tick(sec_tick), .fast_tick(fast_tick),
        .alarm_irq(alarm_irq), .wake_irq(wake_irq), .dpd_wake(dpd_wake),
        .osc_powerdown_out(osc_powerdown_out), .irq(irq));

    // Clock generator
    always #25 mclk = ~mclk;

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task tally_and_finish;
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Step to the settled middle of a later cycle
    task look(input integer k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask

    task bus_wr(input [4:0] a, input [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'h1;
        do @(posedge mclk); while (avs_waitrequest !== 1'h0);
        avs_write <= 1'h0;
    endtask

    task bus_rd(input [4:0] a, input [31:0] e);
        expq.push_back(e);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'h1;
        do @(posedge mclk); while (avs_waitrequest !== 1'h0);
        avs_read <= 1'h0;
    endtask

    task pulse_wake;
        @(posedge mclk);
        wake_timer_expired <= 1'h1;
        @(posedge mclk);
        wake_timer_expired <= 1'h0;
    endtask

    // Read answers, fast tick count and hang guard
    always @(posedge mclk) begin
        cycles++;
        if (avs_read && avs_waitrequest === 1'h0)
            check("readdata", avs_readdata, expq.pop_front());
        if (fast_tick === 1'h1)
            fast_n++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'h1;
        bus_rd(5'h00, 32'h1);
        bus_rd(5'h04, 32'hffffffff);
        bus_rd(5'h08, 32'h0);
        bus_wr(5'h00, 32'h0c0);
        bus_rd(5'h00, 32'h0);
        repeat (4) begin
            v = $random(seed);
            bus_wr(5'h04, v);
            bus_rd(5'h04, v);
        end
        avs_byteenable <= 4'h1;
        bus_wr(5'h04, 32'h0);
        avs_byteenable <= 4'hf;
        bus_rd(5'h04, {v[31:8], 8'h00});
        count_load_value <= 32'h5;
        count_load <= 1'h1;
        @(posedge mclk);
        count_load <= 1'h0;
        look(1);
        check("count", seconds_count, 32'h5);
        bus_wr(5'h04, 32'h7);
        bus_wr(5'h10, 32'h3);
        bus_wr(5'h00, 32'h0f0);
        look(SEC - 3);
        check("count", seconds_count, 32'h5);
        look(5);
        check("count", seconds_count, 32'h6);
        n = 0;
        while (alarm_irq !== 1'h1 && n < 40) begin
            look(1);
            n++;
        end
        check("count", seconds_count, 32'h7);
        look(1);
        check("irq", irq, 32'h1);
        check("dpd", dpd_wake, 32'h1);
        bus_wr(5'h14, 32'h0);
        look(1);
        check("alarm", alarm_irq, 32'h1);
        n = 0;
        while (seconds_count !== 32'h8 && n < 30) begin
            look(1);
            n++;
        end
        bus_wr(5'h00, 32'h0f4);
        look(1);
        check("alarm", alarm_irq, 32'h0);
        bus_rd(5'h14, 32'h0);
        pulse_wake;
        look(2);
        check("wake", wake_irq, 32'h1);
        check("dpd", dpd_wake, 32'h1);
        bus_rd(5'h14, 32'h2);
        bus_wr(5'h10, 32'h1);
        look(1);
        check("irq", irq, 32'h0);
        bus_rd(5'h10, 32'h1);
        bus_wr(5'h00, 32'h090);
        look(1);
        check("wake", wake_irq, 32'h0);
        pulse_wake;
        look(2);
        check("wake", wake_irq, 32'h0);
        bus_wr(5'h00, 32'h0c0);
        pulse_wake;
        look(2);
        check("wake", wake_irq, 32'h1);
        check("dpd", dpd_wake, 32'h0);
        bus_wr(5'h14, 32'h2);
        look(1);
        check("wake", wake_irq, 32'h0);
        fast_n = 0;
        look(50);
        check("fast", fast_n >= 9 && fast_n <= 11, 32'h1);
        for (n = 0; n < 2; n++) begin
            bus_wr(5'h00, n ? 32'h1c0 : 32'h040);
            look(1);
            check("osc", osc_powerdown_out, n);
            c = seconds_count;
            fast_n = 0;
            look(50);
            check("fast", fast_n, 32'h0);
            check("count", seconds_count, c);
        end
        bus_wr(5'h00, 32'h0c0);
        look(SEC + 3);
        check("count", seconds_count, c + 32'h1);
        tally_and_finish;
    end
endmodule
